// [ldp_pkg.sv]
// Shared constants, types and decode helpers for the load instruction datapath
package ldp_pkg;

	// Data path widths
	localparam int XLEN = 64;
	localparam int REGW = 5;

	// Instruction field positions
	localparam int OPC_HI = 31;
	localparam int OPC_LO = 26;
	localparam int BASE_HI = 25;
	localparam int BASE_LO = 21;
	localparam int TGT_HI = 20;
	localparam int TGT_LO = 16;
	localparam int OFS_HI = 15;
	localparam int OFS_LO = 0;

	// Primary opcodes of the group, and of the left-hand load outside it
	localparam logic [5:0] OP_LOAD_DOUBLE_RIGHT = 6'h1b;
	localparam logic [5:0] OP_LOAD_DOUBLE_LEFT = 6'h1a;
	localparam logic [5:0] OP_LOAD_HALF_SIGNED = 6'h21;
	localparam logic [5:0] OP_LOAD_HALF_UNSIGNED = 6'h25;
	localparam logic [5:0] OP_LOAD_UPPER_IMMEDIATE = 6'h0f;
	localparam logic [5:0] OP_LOAD_WORD_SIGNED = 6'h23;

	// Access types sent to the memory port (bytes minus one)
	localparam logic [2:0] ACC_HALF = 3'h1;
	localparam logic [2:0] ACC_WORD = 3'h3;
	localparam logic [2:0] ACC_DOUBLE = 3'h7;

	// Alignment masks on the low effective-address bits
	localparam logic [2:0] HALF_ALIGN_MASK = 3'h1;
	localparam logic [2:0] WORD_ALIGN_MASK = 3'h3;

	// Reset values
	localparam logic [63:0] DATA_RST = 64'h0;
	localparam logic [4:0] INDEX_RST = 5'h0;

	typedef enum logic [2:0] {
		KIND_NONE = 3'h0,
		KIND_DOUBLE_RIGHT = 3'h1,
		KIND_HALF_SIGNED = 3'h2,
		KIND_HALF_UNSIGNED = 3'h3,
		KIND_UPPER_IMM = 3'h4,
		KIND_WORD = 3'h5
	} ldp_kind_t;

	typedef enum logic [2:0] {
		EXC_NONE = 3'h0,
		EXC_ADDR_ERR = 3'h1,
		EXC_RESERVED = 3'h2,
		EXC_TLB_REFILL = 3'h3,
		EXC_TLB_INVALID = 3'h4,
		EXC_BUS_ERR = 3'h5
	} ldp_exc_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MEM = 2'b01
	} ldp_state_t;

	// Opcode to operation kind
	function automatic ldp_kind_t ldp_decode(input logic [5:0] opc);
		case (opc)
			OP_LOAD_DOUBLE_RIGHT: ldp_decode = KIND_DOUBLE_RIGHT;
			OP_LOAD_HALF_SIGNED: ldp_decode = KIND_HALF_SIGNED;
			OP_LOAD_HALF_UNSIGNED: ldp_decode = KIND_HALF_UNSIGNED;
			OP_LOAD_UPPER_IMMEDIATE: ldp_decode = KIND_UPPER_IMM;
			OP_LOAD_WORD_SIGNED: ldp_decode = KIND_WORD;
			default: ldp_decode = KIND_NONE;
		endcase
	endfunction : ldp_decode

	// Kinds that go out to the memory port
	function automatic logic ldp_is_mem(input ldp_kind_t k);
		ldp_is_mem = (k != KIND_NONE) && (k != KIND_UPPER_IMM);
	endfunction : ldp_is_mem

endpackage : ldp_pkg

// [ldp_addr_gen.sv]
// Effective address, alignment check, access type and byte lane for one load
`timescale 1ns/1ps
`default_nettype none
module ldp_addr_gen (
	input wire logic [63:0] base_value,
	input wire logic [15:0] offset,
	input wire logic mode64,
	input wire ldp_pkg::ldp_kind_t kind,
	input wire logic memory_byte_order_high_first,
	input wire logic core_byte_order_high_first,
	input wire logic user_byte_order_swap,
	output logic [63:0] virt_effective_address,
	output logic [2:0] access_type,
	output logic [2:0] low_offset,
	output logic [2:0] lane,
	output logic align_err
);
	import ldp_pkg::*;

	logic [63:0] sum;
	logic [2:0] va;
	logic [2:0] swap3;
	logic [2:0] cpu3;

	// Sign-extended offset plus base; 32-bit mode keeps a sign-extended word address
	always_comb begin
		sum = base_value + {{48{offset[15]}}, offset};
		virt_effective_address = mode64 ? sum : {{32{sum[31]}}, sum[31:0]};
	end

	assign va = virt_effective_address[2:0];
	assign swap3 = {3{user_byte_order_swap}};
	assign cpu3 = {3{core_byte_order_high_first}};

	// Per-kind lane and memory offset; the swap flag only touches the address bits it spans
	always_comb begin
		access_type = ACC_DOUBLE;
		low_offset = va;
		lane = va;
		align_err = 1'b0;
		case (kind)
			KIND_DOUBLE_RIGHT: begin
				// Any byte address is legal here, so no alignment error
				lane = va ^ cpu3;
				access_type = ACC_DOUBLE - lane;
				low_offset = memory_byte_order_high_first ? 3'h0 : (va ^ swap3);
			end
			KIND_HALF_SIGNED, KIND_HALF_UNSIGNED: begin
				access_type = ACC_HALF;
				low_offset = va ^ {user_byte_order_swap, user_byte_order_swap, 1'b0};
				lane = va ^ {core_byte_order_high_first, core_byte_order_high_first, 1'b0};
				align_err = |(va & HALF_ALIGN_MASK);
			end
			KIND_WORD: begin
				access_type = ACC_WORD;
				low_offset = va ^ {user_byte_order_swap, 2'b00};
				lane = va ^ {core_byte_order_high_first, 2'b00};
				align_err = |(va & WORD_ALIGN_MASK);
			end
			default: begin
				access_type = ACC_DOUBLE;
			end
		endcase
	end

endmodule : ldp_addr_gen
`default_nettype wire

// [ldp_data_align.sv]
// Lane selection, right-hand byte merge and sign or zero extension of load data
`timescale 1ns/1ps
`default_nettype none
module ldp_data_align (
	input wire ldp_pkg::ldp_kind_t kind,
	input wire logic [2:0] lane,
	input wire logic mode64,
	input wire logic [63:0] mem_rdata,
	input wire logic [63:0] target_old,
	input wire logic [15:0] immediate,
	output logic [63:0] result
);
	import ldp_pkg::*;

	logic [63:0] shifted;
	logic [63:0] merged;
	logic [63:0] full;
	logic [15:0] half;
	logic [31:0] word;

	// Bring the addressed lane down to bit zero
	assign shifted = mem_rdata >> {lane, 3'b000};
	assign half = shifted[15:0];
	assign word = shifted[31:0];

	// Low 8-k bytes from memory, top k bytes of the old register kept
	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_merge
			localparam logic [3:0] BIDX = 4'(b);
			assign merged[8*b +: 8] = (({1'b0, lane} + BIDX) >= 4'h8) ?
				target_old[8*b +: 8] : shifted[8*b +: 8];
		end
	endgenerate

	// Extension per kind; in 32-bit mode the upper half of the result is zero
	always_comb begin
		case (kind)
			KIND_HALF_SIGNED: full = {{48{half[15]}}, half};
			KIND_HALF_UNSIGNED: full = {48'h0, half};
			KIND_WORD: full = {{32{word[31]}}, word};
			KIND_UPPER_IMM: full = {{32{immediate[15]}}, immediate, 16'h0};
			KIND_DOUBLE_RIGHT: full = merged;
			default: full = DATA_RST;
		endcase
		result = mode64 ? full : {32'h0, full[31:0]};
	end

endmodule : ldp_data_align
`default_nettype wire

// [ldp_load_unit.sv]
// Load instruction datapath: decode, memory access, exceptions, write-back, bypass
`timescale 1ns/1ps
`default_nettype none
module ldp_load_unit (
	input wire logic clk,
	input wire logic rst,
	// Instruction issue
	input wire logic ins_valid,
	output logic ins_ready,
	input wire logic [31:0] ins_word,
	input wire logic [63:0] base_value,
	input wire logic [63:0] target_value,
	// Mode and byte order
	input wire logic mode64,
	input wire logic kernel_mode,
	input wire logic memory_byte_order_high_first,
	input wire logic core_byte_order_high_first,
	input wire logic user_byte_order_swap,
	// Memory access port
	output logic mem_req,
	output logic [63:0] mem_virt_effective_address,
	output logic [2:0] mem_access_type,
	output logic [2:0] mem_low_offset,
	input wire logic mem_ack,
	input wire logic [63:0] mem_rdata,
	input wire logic mem_tlb_refill,
	input wire logic mem_tlb_invalid,
	input wire logic mem_bus_error,
	// Write-back to the general register file
	output logic wb_en,
	output logic [4:0] wb_index,
	output logic [63:0] wb_data,
	// Exception report
	output logic exc_valid,
	output ldp_pkg::ldp_exc_t exc_code
);
	import ldp_pkg::*;

	// Registered state
	ldp_state_t state_r, state_nxt;
	ldp_kind_t kind_r, kind_nxt;
	logic [4:0] tgt_r, tgt_nxt;
	logic [63:0] old_r, old_nxt;
	logic [2:0] lane_r, lane_nxt;
	logic mode64_r, mode64_nxt;
	logic mem_req_r, mem_req_nxt;
	logic [63:0] virt_effective_address_r, virt_effective_address_nxt;
	logic [2:0] acc_r, acc_nxt;
	logic [2:0] ofs_r, ofs_nxt;
	logic wb_en_r, wb_en_nxt;
	logic [4:0] wb_index_r, wb_index_nxt;
	logic [63:0] wb_data_r, wb_data_nxt;
	logic exc_valid_r, exc_valid_nxt;
	ldp_exc_t exc_code_r, exc_code_nxt;
	logic byp_valid_r, byp_valid_nxt;
	logic [4:0] byp_index_r, byp_index_nxt;
	logic [63:0] byp_data_r, byp_data_nxt;

	// Decoded fields of the instruction on offer
	ldp_kind_t dec_kind;
	logic [4:0] dec_tgt;
	logic [15:0] dec_ofs;
	logic [63:0] tgt_now;
	logic accept;

	// Address generator outputs
	logic [63:0] ag_virt_effective_address;
	logic [2:0] ag_acc;
	logic [2:0] ag_ofs;
	logic [2:0] ag_lane;
	logic ag_align_err;

	// Data align inputs and output
	ldp_kind_t al_kind;
	logic [2:0] al_lane;
	logic al_mode64;
	logic [63:0] al_old;
	logic [63:0] al_result;

	// Field extraction; only the opcodes of the group are recognised
	assign dec_kind = ldp_decode(ins_word[OPC_HI:OPC_LO]);
	assign dec_tgt = ins_word[TGT_HI:TGT_LO];
	assign dec_ofs = ins_word[OFS_HI:OFS_LO];

	// One instruction in flight at a time, so ready is simply idle
	assign ins_ready = (state_r == ST_IDLE);
	assign accept = ins_ready && ins_valid;

	// The register file has not yet seen the last load, so take its result from here
	assign tgt_now = (byp_valid_r && (byp_index_r == dec_tgt)) ? byp_data_r : target_value;

	ldp_addr_gen u_addr (
		.base_value(base_value),
		.offset(dec_ofs),
		.mode64(mode64),
		.kind(dec_kind),
		.memory_byte_order_high_first(memory_byte_order_high_first),
		.core_byte_order_high_first(core_byte_order_high_first),
		.user_byte_order_swap(user_byte_order_swap),
		.virt_effective_address(ag_virt_effective_address),
		.access_type(ag_acc),
		.low_offset(ag_ofs),
		.lane(ag_lane),
		.align_err(ag_align_err)
	);

	// Upper immediate resolves at issue; memory kinds resolve on the answer
	always_comb begin
		if (state_r == ST_IDLE) begin
			al_kind = dec_kind;
			al_lane = ag_lane;
			al_mode64 = mode64;
			al_old = tgt_now;
		end else begin
			al_kind = kind_r;
			al_lane = lane_r;
			al_mode64 = mode64_r;
			al_old = old_r;
		end
	end

	ldp_data_align u_align (
		.kind(al_kind),
		.lane(al_lane),
		.mode64(al_mode64),
		.mem_rdata(mem_rdata),
		.target_old(al_old),
		.immediate(dec_ofs),
		.result(al_result)
	);

	// Sequencer: decode and check at issue, then wait for the memory answer
	always_comb begin
		state_nxt = state_r;
		kind_nxt = kind_r;
		tgt_nxt = tgt_r;
		old_nxt = old_r;
		lane_nxt = lane_r;
		mode64_nxt = mode64_r;
		mem_req_nxt = mem_req_r;
		virt_effective_address_nxt = virt_effective_address_r;
		acc_nxt = acc_r;
		ofs_nxt = ofs_r;
		wb_en_nxt = 1'b0;
		wb_index_nxt = wb_index_r;
		wb_data_nxt = wb_data_r;
		exc_valid_nxt = 1'b0;
		exc_code_nxt = exc_code_r;
		byp_valid_nxt = byp_valid_r;
		byp_index_nxt = byp_index_r;
		byp_data_nxt = byp_data_r;
		case (state_r)
			ST_IDLE: begin
				if (accept) begin
					// Forwarding covers only the next instruction
					byp_valid_nxt = 1'b0;
					if (dec_kind == KIND_DOUBLE_RIGHT && !mode64 && !kernel_mode) begin
						exc_valid_nxt = 1'b1;
						exc_code_nxt = EXC_RESERVED;
					end else if (ag_align_err) begin
						// No memory access and no write on a misaligned address
						exc_valid_nxt = 1'b1;
						exc_code_nxt = EXC_ADDR_ERR;
					end else if (dec_kind == KIND_UPPER_IMM) begin
						wb_en_nxt = 1'b1;
						wb_index_nxt = dec_tgt;
						wb_data_nxt = al_result;
					end else if (ldp_is_mem(dec_kind)) begin
						state_nxt = ST_MEM;
						kind_nxt = dec_kind;
						tgt_nxt = dec_tgt;
						old_nxt = tgt_now;
						lane_nxt = ag_lane;
						mode64_nxt = mode64;
						mem_req_nxt = 1'b1;
						virt_effective_address_nxt = ag_virt_effective_address;
						acc_nxt = ag_acc;
						ofs_nxt = ag_ofs;
					end
				end
			end
			ST_MEM: begin
				if (mem_ack) begin
					state_nxt = ST_IDLE;
					mem_req_nxt = 1'b0;
					// Translation faults outrank a bus error; any fault drops the write
					if (mem_tlb_refill) begin
						exc_valid_nxt = 1'b1;
						exc_code_nxt = EXC_TLB_REFILL;
					end else if (mem_tlb_invalid) begin
						exc_valid_nxt = 1'b1;
						exc_code_nxt = EXC_TLB_INVALID;
					end else if (mem_bus_error) begin
						exc_valid_nxt = 1'b1;
						exc_code_nxt = EXC_BUS_ERR;
					end else begin
						wb_en_nxt = 1'b1;
						wb_index_nxt = tgt_r;
						wb_data_nxt = al_result;
						byp_valid_nxt = 1'b1;
						byp_index_nxt = tgt_r;
						byp_data_nxt = al_result;
					end
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				mem_req_nxt = 1'b0;
			end
		endcase
	end

	// State registers with synchronous reset
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= ST_IDLE;
			kind_r <= KIND_NONE;
			tgt_r <= INDEX_RST;
			old_r <= DATA_RST;
			lane_r <= 3'h0;
			mode64_r <= 1'b0;
			mem_req_r <= 1'b0;
			virt_effective_address_r <= DATA_RST;
			acc_r <= 3'h0;
			ofs_r <= 3'h0;
			wb_en_r <= 1'b0;
			wb_index_r <= INDEX_RST;
			wb_data_r <= DATA_RST;
			exc_valid_r <= 1'b0;
			exc_code_r <= EXC_NONE;
			byp_valid_r <= 1'b0;
			byp_index_r <= INDEX_RST;
			byp_data_r <= DATA_RST;
		end else begin
			state_r <= state_nxt;
			kind_r <= kind_nxt;
			tgt_r <= tgt_nxt;
			old_r <= old_nxt;
			lane_r <= lane_nxt;
			mode64_r <= mode64_nxt;
			mem_req_r <= mem_req_nxt;
			virt_effective_address_r <= virt_effective_address_nxt;
			acc_r <= acc_nxt;
			ofs_r <= ofs_nxt;
			wb_en_r <= wb_en_nxt;
			wb_index_r <= wb_index_nxt;
			wb_data_r <= wb_data_nxt;
			exc_valid_r <= exc_valid_nxt;
			exc_code_r <= exc_code_nxt;
			byp_valid_r <= byp_valid_nxt;
			byp_index_r <= byp_index_nxt;
			byp_data_r <= byp_data_nxt;
		end
	end

	// All outputs straight from flip-flops except ready
	assign mem_req = mem_req_r;
	assign mem_virt_effective_address = virt_effective_address_r;
	assign mem_access_type = acc_r;
	assign mem_low_offset = ofs_r;
	assign wb_en = wb_en_r;
	assign wb_index = wb_index_r;
	assign wb_data = wb_data_r;
	assign exc_valid = exc_valid_r;
	assign exc_code = exc_code_r;

endmodule : ldp_load_unit
`default_nettype wire

// [ldp_checker.sv]
// Port-level assertions for the load unit
`timescale 1ns/1ps
`default_nettype none
module ldp_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic ins_valid,
	input wire logic ins_ready,
	input wire logic [31:0] ins_word,
	input wire logic [63:0] base_value,
	input wire logic mode64,
	input wire logic kernel_mode,
	input wire logic mem_req,
	input wire logic [63:0] mem_virt_effective_address,
	input wire logic mem_ack,
	input wire logic mem_tlb_refill,
	input wire logic wb_en,
	input wire logic [63:0] wb_data,
	input wire logic exc_valid,
	input wire ldp_pkg::ldp_exc_t exc_code
);
	import ldp_pkg::*;
	logic acc;
	logic [5:0] op;
	logic [63:0] va;
	// Issue-side view: accept, opcode and effective address
	assign acc = ins_valid && ins_ready;
	assign op = ins_word[31:26];
	assign va = base_value + {{48{ins_word[15]}}, ins_word[15:0]};
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_upper_wide: assert property (acc && op == 6'h0f && mode64 |=> wb_en &&
		wb_data == {{32{$past(ins_word[15])}}, $past(ins_word[15:0]), 16'h0})
		else $error("upper immediate wrong in 64-bit mode");
	a_upper_narrow: assert property (acc && op == 6'h0f && !mode64 |=> wb_en &&
		wb_data == {32'h0, $past(ins_word[15:0]), 16'h0})
		else $error("upper immediate wrong in 32-bit mode");
	a_half_align: assert property (acc && (op == 6'h21 || op == 6'h25) && va[0] |=>
		exc_valid && exc_code == EXC_ADDR_ERR && !wb_en)
		else $error("odd halfword address not refused");
	a_word_align: assert property (acc && op == 6'h23 && va[1:0] != 2'h0 |=>
		exc_valid && exc_code == EXC_ADDR_ERR)
		else $error("misaligned word address not refused");
	a_right_reserved: assert property (acc && op == 6'h1b && !mode64 && !kernel_mode |=>
		exc_valid && exc_code == EXC_RESERVED && !mem_req)
		else $error("right load in user 32-bit mode not reserved");
	a_right_issue: assert property (acc && op == 6'h1b && mode64 |=>
		mem_req && !exc_valid && mem_virt_effective_address == $past(va))
		else $error("right load not issued at its address");
	// Narrow mode keeps a sign-extended word address on the memory port
	a_addr_narrow: assert property (acc && op == 6'h23 && !mode64 && va[1:0] == 2'h0 |=>
		mem_req && mem_virt_effective_address == {{32{$past(va[31])}}, $past(va[31:0])})
		else $error("word address wrong in 32-bit mode");
	a_exc_no_write: assert property (exc_valid |-> !wb_en)
		else $error("write with exception");
	a_refill_code: assert property (mem_req && mem_ack && mem_tlb_refill |=>
		exc_valid && exc_code == EXC_TLB_REFILL && !wb_en)
		else $error("refill fault not reported");
	// Main scenarios seen
	c_right: cover property (acc && op == 6'h1b && mode64);
	c_reserved: cover property (exc_valid && exc_code == EXC_RESERVED);
	c_refill: cover property (mem_ack && mem_tlb_refill);
endmodule : ldp_checker
bind ldp_load_unit ldp_checker u_chk (.*);
`default_nettype wire

// [ldp_mem_model.sv]
// Behavioural memory access port for the load unit
`timescale 1ns/1ps
`default_nettype none
module ldp_mem_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic mem_req,
	input wire logic [3:0] mem_delay,
	input wire logic [2:0] mem_fault,
	input wire logic [63:0] mem_data,
	output logic mem_ack,
	output logic [63:0] mem_rdata,
	output logic mem_tlb_refill,
	output logic mem_tlb_invalid,
	output logic mem_bus_error
);
	logic [3:0] wait_r;
	// One ack pulse per request after a programmable wait
	always_ff @(posedge clk) begin
		if (rst || !mem_req || mem_ack) begin
			mem_ack <= 1'b0;
			wait_r <= 4'h0;
		end else if (wait_r == mem_delay) begin
			mem_ack <= 1'b1;
		end else begin
			wait_r <= wait_r + 4'h1;
		end
	end
	// Data inverted outside ack so a stale sample shows up
	assign mem_rdata = mem_ack ? mem_data : ~mem_data;
	assign mem_tlb_refill = mem_ack & mem_fault[0];
	assign mem_tlb_invalid = mem_ack & mem_fault[1];
	assign mem_bus_error = mem_ack & mem_fault[2];
endmodule : ldp_mem_model
`default_nettype wire

// [test_load_instruction_datapath.sv]
// Self-checking bench for the load instruction datapath
`timescale 1ns/1ps
`default_nettype none
module test_load_instruction_datapath;
	import ldp_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ins_valid = 1'b0;
	logic mode64 = 1'b1;
	logic kernel_mode = 1'b0;
	logic memory_byte_order_high_first = 1'b0;
	logic core_byte_order_high_first = 1'b0;
	logic user_byte_order_swap = 1'b0;
	logic [31:0] ins_word = 32'h0;
	logic [63:0] base_value = 64'h0;
	logic [63:0] target_value = 64'h0;
	logic [63:0] mem_data = 64'h8899aabbccddeeff;
	logic [3:0] mem_delay = 4'h0;
	logic [2:0] mem_fault = 3'h0;
	logic [4:0] tgt = 5'h1;
	logic ins_ready, mem_req, mem_ack, mem_tlb_refill, mem_tlb_invalid, mem_bus_error;
	logic wb_en, exc_valid, gwb;
	logic [63:0] mem_virt_effective_address, mem_rdata, wb_data, got;
	logic [2:0] mem_access_type, mem_low_offset, gtype, goff;
	logic [4:0] wb_index, used;
	ldp_exc_t exc_code, gcode;
	int err_count = 0;
	int tests_run = 0;

	ldp_load_unit u_dut (.*);
	ldp_mem_model u_mem (.*);

	// Core clock, 4 ns period
	always #2 clk = ~clk;

	task automatic complete_run();
		$display("errors %0d checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run

	task automatic chk(input string n, input logic [63:0] e, g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic chkc(input string n, input ldp_exc_t e, g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
		end
	endtask : chkc

	// Issue one instruction at a falling edge and wait for its answer
	task automatic run(input logic [5:0] op, input logic [15:0] ofs, input logic [63:0] b, t);
		ins_word = {op, 5'h3, tgt, ofs};
		used = tgt;
		tgt = tgt + 5'h1;
		base_value = b;
		target_value = t;
		ins_valid = 1'b1;
		@(posedge clk);
		@(negedge clk);
		ins_valid = 1'b0;
		for (int i = 0; i < 40 && !wb_en && !exc_valid; i++) begin
			gtype = mem_access_type;
			goff = mem_low_offset;
			@(negedge clk);
		end
		gwb = wb_en;
		got = wb_data;
		gcode = exc_valid ? exc_code : EXC_NONE;
	endtask : run

	task automatic ok_wb(input string n, input logic [63:0] e);
		chk("wb_en", 64'h1, 64'(gwb));
		chk(n, e, got);
	endtask : ok_wb

	task automatic ok_exc(input ldp_exc_t e);
		chk("wb_en", 64'h0, 64'(gwb));
		chkc("exc_code", e, gcode);
	endtask : ok_exc

	// Expected right-hand merge: low bytes from memory, top k kept
	function automatic logic [63:0] merge(input logic [63:0] m, o, input int k);
		logic [63:0] r;
		for (int i = 0; i < 8; i++)
			r[8*i +: 8] = (i + k < 8) ? m[8*(i+k) +: 8] : o[8*i +: 8];
		return r;
	endfunction : merge

	task automatic t_upper();
		run(6'h0f, 16'h8000, 64'h0, 64'h0);
		ok_wb("upper64", 64'hffffffff80000000);
		mode64 = 1'b0;
		run(6'h0f, 16'h8000, 64'h0, 64'h0);
		ok_wb("upper32", 64'h0000000080000000);
		mode64 = 1'b1;
		// Left-hand load is outside the group: accepted and dropped silently
		run(6'h1a, 16'h0, 64'h0, 64'h0);
		ok_exc(EXC_NONE);
	endtask : t_upper

	task automatic t_half();
		run(6'h21, 16'hfff2, 64'h10, 64'h0);
		ok_wb("half signed", 64'hffffffffffffccdd);
		chk("wb_index", 64'(used), 64'(wb_index));
		chk("half type", 64'h1, 64'(gtype));
		run(6'h25, 16'hfff2, 64'h10, 64'h0);
		ok_wb("half unsigned", 64'h000000000000ccdd);
		mode64 = 1'b0;
		run(6'h21, 16'h2, 64'h0, 64'h0);
		ok_wb("half signed 32", 64'h00000000ffffccdd);
		run(6'h25, 16'h2, 64'h0, 64'h0);
		ok_wb("half unsigned 32", 64'h000000000000ccdd);
		mode64 = 1'b1;
		run(6'h21, 16'h3, 64'h0, 64'h0);
		ok_exc(EXC_ADDR_ERR);
		run(6'h25, 16'h1, 64'h0, 64'h0);
		ok_exc(EXC_ADDR_ERR);
		core_byte_order_high_first = 1'b1;
		user_byte_order_swap = 1'b1;
		run(6'h25, 16'h2, 64'h0, 64'h0);
		ok_wb("half lane", 64'h000000000000aabb);
		chk("half offset", 64'h4, 64'(goff));
		core_byte_order_high_first = 1'b0;
		user_byte_order_swap = 1'b0;
	endtask : t_half

	task automatic t_word();
		run(6'h23, 16'h4, 64'h0, 64'h0);
		ok_wb("word", 64'hffffffff8899aabb);
		mode64 = 1'b0;
		run(6'h23, 16'h4, 64'h0, 64'h0);
		ok_wb("word32", 64'h000000008899aabb);
		mode64 = 1'b1;
		run(6'h23, 16'h6, 64'h0, 64'h0);
		ok_exc(EXC_ADDR_ERR);
		run(6'h23, 16'h1, 64'h0, 64'h0);
		ok_exc(EXC_ADDR_ERR);
	endtask : t_word

	// Every start byte, with and without the swap flag, slow partner
	task automatic t_right();
		logic [63:0] old = 64'h0123456789abcdef;
		for (int s = 0; s < 2; s++) begin
			user_byte_order_swap = s[0];
			for (int k = 0; k < 8; k++) begin
				mem_delay = 4'(k);
				run(6'h1b, 16'(k), 64'h0, old);
				ok_wb("right data", merge(mem_data, old, k));
				chk("right type", 64'(7 - k), 64'(gtype));
				chk("right offset", 64'(3'(k) ^ {3{s[0]}}), 64'(goff));
			end
		end
		memory_byte_order_high_first = 1'b1;
		run(6'h1b, 16'h3, 64'h0, old);
		chk("right offset big", 64'h0, 64'(goff));
		memory_byte_order_high_first = 1'b0;
		user_byte_order_swap = 1'b0;
		mem_delay = 4'h0;
	endtask : t_right

	task automatic t_reserved();
		mode64 = 1'b0;
		run(6'h1b, 16'h5, 64'h0, 64'h0);
		ok_exc(EXC_RESERVED);
		kernel_mode = 1'b1;
		run(6'h1b, 16'h0, 64'h0, 64'h0);
		chk("kernel right", 64'h1, 64'(gwb));
		kernel_mode = 1'b0;
		mode64 = 1'b1;
	endtask : t_reserved

	task automatic t_faults();
		ldp_exc_t ex[3] = '{EXC_TLB_REFILL, EXC_TLB_INVALID, EXC_BUS_ERR};
		for (int f = 0; f < 3; f++) begin
			mem_fault = 3'(1 << f);
			mem_delay = 4'(f);
			run(6'h23, 16'h0, 64'h0, 64'h0);
			ok_exc(ex[f]);
		end
		mem_fault = 3'h7;
		run(6'h23, 16'h0, 64'h0, 64'h0);
		ok_exc(EXC_TLB_REFILL);
		mem_fault = 3'h0;
		mem_delay = 4'h0;
	endtask : t_faults

	// Right load straight after a load to the same target
	task automatic t_bypass();
		run(6'h23, 16'h0, 64'h0, 64'h0);
		ok_wb("word low", 64'hffffffffccddeeff);
		tgt = used;
		run(6'h1b, 16'h4, 64'h0, 64'h0);
		ok_wb("forwarded", 64'hffffffff8899aabb);
	endtask : t_bypass

	// Main sequence
	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		t_upper();
		t_half();
		t_word();
		t_right();
		t_reserved();
		t_faults();
		t_bypass();
		complete_run();
	end

	// Watchdog well beyond the expected run length
	initial begin
		#20000;
		err_count++;
		complete_run();
	end
endmodule : test_load_instruction_datapath
`default_nettype wire
